// >>> column_correction_pkg.sv
package column_correction_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ctrl_addr     = 8'h00;
  localparam logic [7:0] table_x_addr  = 8'h04;
  localparam logic [7:0] user_gain_addr = 8'h08;
  localparam logic [7:0] user_off_addr = 8'h0C;
  localparam logic [7:0] command_addr  = 8'h10;
  localparam logic [7:0] status_addr   = 8'h14;
  localparam logic [7:0] step_addr     = 8'h18;
  localparam logic [7:0] cam_gain_addr = 8'h1C;
  localparam logic [7:0] fact_x_addr   = 8'h20;
  localparam logic [7:0] fact_gain_addr = 8'h24;
  localparam logic [7:0] fact_off_addr = 8'h28;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_mode_lsb   = 4;
  localparam int cmd_reset_bit   = 0;
  localparam int cmd_save_bit    = 1;
  localparam int st_error_bit    = 0;
  localparam int st_busy_bit     = 1;
  localparam int st_saved_bit    = 2;
  localparam int st_mode_lsb     = 4;
  localparam int st_active_bit   = 8;

  // ****************************************
  // reset values and coefficient format
  // ****************************************
  localparam int gain_frac_bits = 14;
  localparam logic [15:0] unity_gain  = 16'h4000;
  localparam logic [15:0] zero_offset = 16'h0000;
  localparam logic [15:0] offset_step_reset = 16'h0020;
  localparam logic enable_reset = 1'b1;

  typedef enum logic [1:0] {
    mode_factory,
    mode_user,
    mode_calibration
  } corr_mode_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } coeff_t;

  typedef struct packed {
    logic        valid;
    logic        frame_start;
    logic        line_start;
    logic [15:0] data;
  } pixel_t;

endpackage

// >>> column_correction.sv
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps

// Overview of operation
// - corrected pixel equals gain times the sum of pixel and offset
// - coefficients chosen by column counter, plus gain level in factory mode, never by row
// - correction enabled after reset
// - three coefficient source modes: factory, user, calibration
// - factory mode selected after reset
// - factory mode picks coefficient bank by camera gain level
// - user mode uses one fixed user table for every gain level
// - user table defaults are unity gain and zero offset
// - calibration mode allows reading and writing the user table
// - calibration forces correction off, enable bit ignored
// - calibration edits show only after user mode and enable
// - horizontal coordinate selects the user table column entry
// - gain access reaches user gain at current coordinate
// - offset access reaches 16-bit user offset at current coordinate
// - offset not multiple of step is rejected and flags an error
// - table reset reloads saved copy, else defaults
// - table save copies the user table to the saved store
// - each save replaces the one saved copy entirely
// - reset and save are write-only triggers
module column_correction
  import column_correction_pkg::*;
#(
  parameter int columns     = 64,
  parameter int gain_levels = 4,
  parameter int pixel_bits  = 16
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire pixel_t      pixel_in,
  output pixel_t           pixel_out
);

  localparam int col_bits = $clog2(columns);
  localparam int lvl_bits = (gain_levels > 1) ? $clog2(gain_levels) : 1;
  localparam int sum_bits = 18;
  localparam int prod_bits = 34;

  initial begin
    if (columns < 2 || columns > 4096 || pixel_bits < 1 || pixel_bits > 16
        || gain_levels < 1 || gain_levels > 16) begin
      $error("column_correction: unsupported parameter values");
    end
  end

  // ****************************************
  // storage
  // ****************************************
  coeff_t user_table   [columns];
  coeff_t saved_table  [columns];
  coeff_t factory_table[gain_levels*columns];

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic             wr_pend_reg;
  logic             rd_pend_reg;
  logic [7:0]       addr_reg;
  logic             enable_reg;
  corr_mode_t       mode_reg;
  corr_mode_t       active_mode_reg;
  logic             active_enable_reg;
  logic [col_bits-1:0] table_x_reg;
  logic [15:0]      step_reg;
  logic [lvl_bits-1:0] cam_gain_reg;
  logic [lvl_bits-1:0] active_level_reg;
  logic [col_bits+lvl_bits-1:0] fact_x_reg;
  logic             error_reg;
  logic             saved_reg;
  logic             loading_reg;
  logic             load_saved_reg;
  logic             saving_reg;
  logic [col_bits-1:0] copy_idx_reg;
  logic             take;
  logic             wr_off;
  logic             cal;
  logic             off_ok;

  assign take = hsel_in & hready_in & htrans_in[1];
  // one wait state per read so that hrdata stands when the master samples it
  assign hreadyout_out = ~rd_pend_reg;
  assign hresp_out = 1'b0;
  assign cal = (mode_reg == mode_calibration);
  assign off_ok = (step_reg == 16'h0000) ? 1'b1 : ((hwdata_in[15:0] % step_reg) == 16'h0000);
  assign wr_off  = wr_pend_reg & (addr_reg == user_off_addr);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite_in;
      rd_pend_reg <= take & ~hwrite_in;
      if (take) begin
        addr_reg <= haddr_in[7:0];
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg   <= enable_reset;
      mode_reg     <= mode_factory;
      table_x_reg  <= '0;
      step_reg     <= offset_step_reset;
      cam_gain_reg <= '0;
      fact_x_reg   <= '0;
    end else if (wr_pend_reg) begin
      unique case (addr_reg)
        ctrl_addr: begin
          enable_reg <= hwdata_in[ctrl_enable_bit];
          if (hwdata_in[ctrl_mode_lsb+1:ctrl_mode_lsb] != 2'b11) begin
            mode_reg <= corr_mode_t'(hwdata_in[ctrl_mode_lsb+1:ctrl_mode_lsb]);
          end
        end
        table_x_addr: begin
          if (cal) begin
            table_x_reg <= hwdata_in[col_bits-1:0];
          end
        end
        step_addr:     step_reg <= hwdata_in[15:0];
        cam_gain_addr: cam_gain_reg <= hwdata_in[lvl_bits-1:0];
        fact_x_addr:   fact_x_reg <= hwdata_in[col_bits+lvl_bits-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // offset error flag, set wins over clear
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      error_reg <= 1'b0;
    end else if (wr_off & cal & ~off_ok) begin
      error_reg <= 1'b1;
    end else if (wr_pend_reg & (addr_reg == status_addr) & hwdata_in[st_error_bit]) begin
      error_reg <= 1'b0;
    end
  end

  // ****************************************
  // table copy engine for reset and save
  // ****************************************
  logic cmd_wr;
  assign cmd_wr = wr_pend_reg & (addr_reg == command_addr) & ~loading_reg & ~saving_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      loading_reg    <= 1'b1;
      load_saved_reg <= 1'b0;
      saving_reg     <= 1'b0;
      saved_reg      <= 1'b0;
      copy_idx_reg   <= '0;
    end else if (loading_reg | saving_reg) begin
      copy_idx_reg <= copy_idx_reg + 1'b1;
      if (copy_idx_reg == col_bits'(columns - 1)) begin
        if (saving_reg) begin
          saved_reg <= 1'b1;
        end
        loading_reg <= 1'b0;
        saving_reg  <= 1'b0;
      end
    end else if (cmd_wr & hwdata_in[cmd_reset_bit]) begin
      loading_reg    <= 1'b1;
      load_saved_reg <= saved_reg;
      copy_idx_reg   <= '0;
    end else if (cmd_wr & hwdata_in[cmd_save_bit]) begin
      saving_reg   <= 1'b1;
      copy_idx_reg <= '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (loading_reg) begin
      user_table[copy_idx_reg] <= load_saved_reg ? saved_table[copy_idx_reg]
                                                 : coeff_t'({unity_gain, zero_offset});
    end else if (wr_pend_reg & cal & (addr_reg == user_gain_addr)) begin
      user_table[table_x_reg].gain <= hwdata_in[15:0];
    end else if (wr_off & cal & off_ok) begin
      user_table[table_x_reg].offset <= hwdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (saving_reg) begin
      saved_table[copy_idx_reg] <= user_table[copy_idx_reg];
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_pend_reg & (addr_reg == fact_gain_addr)) begin
      factory_table[fact_x_reg].gain <= hwdata_in[15:0];
    end else if (wr_pend_reg & (addr_reg == fact_off_addr)) begin
      factory_table[fact_x_reg].offset <= hwdata_in[15:0];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (addr_reg)
      ctrl_addr: begin
        rd_value[ctrl_enable_bit] = enable_reg;
        rd_value[ctrl_mode_lsb+1:ctrl_mode_lsb] = mode_reg;
      end
      table_x_addr:   rd_value[col_bits-1:0] = table_x_reg;
      user_gain_addr: rd_value[15:0] = cal ? user_table[table_x_reg].gain : 16'h0000;
      user_off_addr:  rd_value[15:0] = cal ? user_table[table_x_reg].offset : 16'h0000;
      status_addr: begin
        rd_value[st_error_bit]  = error_reg;
        rd_value[st_busy_bit]   = loading_reg | saving_reg;
        rd_value[st_saved_bit]  = saved_reg;
        rd_value[st_mode_lsb+1:st_mode_lsb] = active_mode_reg;
        rd_value[st_active_bit] = active_enable_reg;
      end
      step_addr:     rd_value[15:0] = step_reg;
      cam_gain_addr: rd_value[lvl_bits-1:0] = cam_gain_reg;
      fact_x_addr:   rd_value[col_bits+lvl_bits-1:0] = fact_x_reg;
      default:       rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (take & ~hwrite_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_out <= rd_value;
    end
  end

  // ****************************************
  // frame-boundary settings and column counter
  // ****************************************
  logic [col_bits-1:0] col_reg;
  logic [col_bits-1:0] col_now;
  assign col_now = pixel_in.line_start ? '0 : col_reg;

  // settings seen by the first pixel of a frame are the newly latched ones
  logic                frame_load;
  corr_mode_t          use_mode;
  logic                use_enable;
  logic [lvl_bits-1:0] use_level;
  assign frame_load = pixel_in.valid & pixel_in.frame_start & ~loading_reg;
  assign use_mode   = frame_load ? mode_reg : active_mode_reg;
  assign use_enable = frame_load ? (enable_reg & ~cal) : active_enable_reg;
  assign use_level  = frame_load ? cam_gain_reg : active_level_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      active_mode_reg   <= mode_factory;
      active_enable_reg <= enable_reset;
      active_level_reg  <= '0;
      col_reg           <= '0;
    end else if (pixel_in.valid) begin
      if (pixel_in.frame_start & ~loading_reg) begin
        active_mode_reg   <= mode_reg;
        active_enable_reg <= enable_reg & ~cal;
        active_level_reg  <= cam_gain_reg;
      end
      col_reg <= (col_now == col_bits'(columns - 1)) ? '0 : col_now + 1'b1;
    end
  end

  // ****************************************
  // correction datapath
  // ****************************************
  function automatic logic [pixel_bits-1:0] clamp_pixel(input logic signed [prod_bits-1:0] v);
    logic signed [prod_bits-1:0] maxv;
    maxv = prod_bits'((64'sd1 <<< pixel_bits) - 64'sd1);
    if (v < 0) begin
      clamp_pixel = '0;
    end else if (v > maxv) begin
      clamp_pixel = '1;
    end else begin
      clamp_pixel = v[pixel_bits-1:0];
    end
  endfunction

  coeff_t                      coef;
  logic signed [sum_bits-1:0]  sum;
  logic signed [prod_bits-1:0] prod;
  logic                        bypass;

  always_comb begin
    coef = (use_mode == mode_user) ? user_table[col_now]
         : factory_table[{use_level, col_now}];
    sum  = $signed({2'b00, pixel_in.data}) + sum_bits'($signed(coef.offset));
    prod = (prod_bits'(sum) * $signed({18'h00000, coef.gain})) >>> gain_frac_bits;
    bypass = ~use_enable | (use_mode == mode_calibration) | cal;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pixel_out <= '0;
    end else begin
      pixel_out.valid       <= pixel_in.valid;
      pixel_out.frame_start <= pixel_in.frame_start;
      pixel_out.line_start  <= pixel_in.line_start;
      pixel_out.data <= bypass ? pixel_in.data
                               : 16'(clamp_pixel(prod));
    end
  end

endmodule

// >>> column_correction_monitor.sv
`timescale 1ns/10ps
module column_correction_monitor
  import column_correction_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire pixel_t      pixel_in,
  input wire pixel_t      pixel_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ****************************************
  // mode tracking and properties
  // ****************************************
  logic rd_take;
  logic wr_ctrl;
  logic cal_q;
  assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ctrl <= 1'b0;
      cal_q   <= 1'b0;
    end else begin
      wr_ctrl <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == ctrl_addr;
      if (wr_ctrl && hwdata_in[5:4] != 2'h3) begin
        cal_q <= (hwdata_in[5:4] == 2'h2);
      end
    end
  end
  property p_valid; pixel_out.valid == $past(pixel_in.valid); endproperty
  property p_fs; pixel_in.valid && pixel_in.frame_start |=> pixel_out.frame_start; endproperty
  property p_ls; $rose(pixel_out.line_start) |-> $past(pixel_in.line_start); endproperty
  property p_ready; !hreadyout_out |=> hreadyout_out; endproperty
  property p_okay; !hresp_out [*2]; endproperty
  property p_cmd; rd_take && haddr_in[7:0] == command_addr |-> ##2 hrdata_out == 32'h0; endproperty
  property p_gain; rd_take && haddr_in[7:0] == user_gain_addr ##1 !cal_q |=> hrdata_out == 32'h0;
  endproperty
  property p_cal; pixel_in.valid && cal_q |=> pixel_out.data == $past(pixel_in.data); endproperty
  a_valid: assert property (p_valid) else $error("pixel valid not one cycle late");
  a_fs: assert property (p_fs) else $error("frame start lost");
  a_ls: assert property (p_ls) else $error("line start out of place");
  a_ready: assert property (p_ready) else $error("bus stalled more than one cycle");
  a_okay: assert property (p_okay) else $error("bus error response");
  a_cmd: assert property (p_cmd) else $error("command word readable");
  a_gain: assert property (p_gain) else $error("user gain open outside calibration");
  a_cal: assert property (p_cal) else $error("pixel altered in calibration");
  c_cal: cover property (pixel_in.valid && cal_q);
  c_cmd: cover property (rd_take && haddr_in[7:0] == command_addr);
  c_fs: cover property (pixel_in.valid && pixel_in.frame_start);
endmodule
bind column_correction column_correction_monitor u_column_correction_monitor (
  .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .pixel_in(pixel_in), .pixel_out(pixel_out));

// >>> pixel_source.sv
`timescale 1ns/10ps
module pixel_source
  import column_correction_pkg::*;
#(
  parameter int cols = 4,
  parameter int rows = 2
) (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [15:0] base_in,
  output pixel_t           pixel_out,
  output logic             busy_out
);
  // ****************************************
  // one frame per request
  // ****************************************
  int n = -1;
  initial pixel_out = '0;
  assign busy_out = (n >= 0);
  always @(posedge clk_in) begin
    if (n >= 0 && n < cols * rows) begin
      pixel_out <= '{1'b1, n == 0, n % cols == 0, base_in + 16'((n / cols) * 256 + n % cols)};
      n <= n + 1;
    end else begin
      pixel_out <= '{1'b0, 1'b0, 1'b0, ~pixel_out.data};
      n <= go_in ? 0 : -1;
    end
  end
endmodule

// >>> column_correction_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module column_correction_tb;
  import column_correction_pkg::*;
  logic        clk_in, reset_in, hsel_in, hwrite_in, go, hreadyout_out, hresp_out, src_busy;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [15:0] base, pe;
  logic [15:0] cg [4], co [4], expq [$];
  pixel_t      pixel_in, pixel_out;
  int          miscompares, checked;
  localparam logic [15:0] g1 [4] = '{16'h8000, 16'h4000, 16'h3000, 16'h5000};
  localparam logic [15:0] o1 [4] = '{16'h7FE0, 16'h8000, 16'h0040, 16'hFFE0};
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  column_correction #(.columns(4), .gain_levels(4), .pixel_bits(16)) u_column_correction (
    .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .pixel_in(pixel_in), .pixel_out(pixel_out));
  pixel_source #(.cols(4), .rows(2)) u_pixel_source (.clk_in(clk_in), .go_in(go),
    .base_in(base), .pixel_out(pixel_in), .busy_out(src_busy));
  // ****************************************
  // bus, stream and expectation helpers
  // ****************************************
  function automatic logic [15:0] fx(input logic [15:0] u, g, o);
    logic signed [40:0] p;
    p = (($signed({1'b0, u}) + $signed(o)) * $signed({1'b0, g})) >>> 14;
    return (p < 0) ? 16'h0000 : ((p > 41'sh0FFFF) ? 16'hFFFF : p[15:0]);
  endfunction
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK("hrdata", e, rd)
    `CHK("hresp", 1'b0, hresp_out)
  endtask
  task automatic wait_idle();
    repeat (20) begin
      bus(status_addr, 1'b0, 32'h0);
      if (rd[st_busy_bit] === 1'b0) break;
    end
    `CHK("busy", 1'b0, rd[st_busy_bit])
  endtask
  task automatic frame(input bit byp);
    logic [15:0] b;
    logic [15:0] u;
    b = 16'($urandom_range(32'h7000, 32'h0100));
    for (int n = 0; n < 8; n++) begin
      u = b + 16'(n / 4 * 256 + n % 4);
      expq.push_back(byp ? u : fx(u, cg[n % 4], co[n % 4]));
    end
    base <= b;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (pixel_out.valid === 1'b1) begin
      pe = (expq.size() != 0) ? expq.pop_front() : 16'hXXXX;
      `CHK("pixel", pe, pixel_out.data)
    end
  end
  initial begin
    #(100 * 20000);
    miscompares++;
    close_out();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset_in, hsel_in, htrans_in, haddr_in, hwrite_in, hwdata_in, go, base} = '0;
    reset_in = 1'b1;
    hsize_in = 3'h2;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'h5B3F08E6));
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk_rd(ctrl_addr, 32'h1);
    chk_rd(step_addr, 32'h20);
    chk_rd(command_addr, 32'h0);
    chk_rd(user_gain_addr, 32'h0);
    wait_idle();
    for (int i = 0; i < 8; i++) begin
      bus(fact_x_addr, 1'b1, i);
      bus(fact_gain_addr, 1'b1, {16'h0, (i < 4) ? unity_gain : g1[i % 4]});
      bus(fact_off_addr, 1'b1, {16'h0, (i < 4) ? 16'h0020 : o1[i % 4]});
    end
    for (int lv = 0; lv < 2; lv++) begin
      bus(cam_gain_addr, 1'b1, lv);
      foreach (cg[c]) begin
        cg[c] = lv ? g1[c] : unity_gain;
        co[c] = lv ? o1[c] : 16'h0020;
      end
      frame(1'b0);
    end
    bus(ctrl_addr, 1'b1, 32'h11);
    foreach (cg[c]) {cg[c], co[c]} = {unity_gain, zero_offset};
    frame(1'b0);
    bus(ctrl_addr, 1'b1, 32'h21);
    bus(table_x_addr, 1'b1, 32'h1);
    bus(user_gain_addr, 1'b1, 32'h7000);
    bus(command_addr, 1'b1, 32'h1);
    wait_idle();
    chk_rd(user_gain_addr, 32'h4000);
    foreach (cg[c]) begin
      bus(table_x_addr, 1'b1, c);
      bus(user_gain_addr, 1'b1, {16'h0, g1[c]});
      bus(user_off_addr, 1'b1, {16'h0, o1[c]});
    end
    bus(table_x_addr, 1'b1, 32'h2);
    chk_rd(user_gain_addr, {16'h0, g1[2]});
    bus(user_off_addr, 1'b1, 32'h21);
    chk_rd(user_off_addr, 32'h40);
    bus(status_addr, 1'b0, 32'h0);
    `CHK("error", 1'b1, rd[st_error_bit])
    frame(1'b1);
    bus(command_addr, 1'b1, 32'h2);
    wait_idle();
    bus(table_x_addr, 1'b1, 32'h0);
    bus(user_gain_addr, 1'b1, 32'h2000);
    bus(command_addr, 1'b1, 32'h2);
    wait_idle();
    bus(user_gain_addr, 1'b1, 32'h6000);
    bus(command_addr, 1'b1, 32'h1);
    wait_idle();
    chk_rd(user_gain_addr, 32'h2000);
    bus(ctrl_addr, 1'b1, 32'h11);
    foreach (cg[c]) {cg[c], co[c]} = {(c == 0) ? 16'h2000 : g1[c], o1[c]};
    for (int lv = 0; lv < 2; lv++) begin
      bus(cam_gain_addr, 1'b1, lv);
      frame(1'b0);
    end
    bus(ctrl_addr, 1'b1, 32'h10);
    frame(1'b1);
    repeat (4) @(posedge clk_in);
    `CHK("queue", 0, expq.size())
    close_out();
  end
endmodule
